// *** design/lvdc_pkg.sv ***
package lvdc_pkg;

  // Register indices; each register fills one aligned word, so its byte address is four times the index
  localparam logic [15:0] LVDC_PWR_DUTY_IDX  = 16'hFF09;
  localparam logic [15:0] LVDC_OUT_FONT_IDX  = 16'hFF10;
  localparam logic [15:0] LVDC_DISP_CTRL_IDX = 16'hFF11;
  localparam logic [15:0] LVDC_SVD_IDX       = 16'hFF12;
  localparam logic [15:0] LVDC_CMP_IDX       = 16'hFF13;
  localparam logic [15:0] LVDC_BUSMODE_IDX   = 16'hFF00;
  localparam logic [15:0] LVDC_STACKPG_IDX   = 16'hFF01;

  // Register byte addresses on the APB word map
  localparam logic [17:0] LVDC_PWR_DUTY_ADDR  = {LVDC_PWR_DUTY_IDX, 2'h0};
  localparam logic [17:0] LVDC_OUT_FONT_ADDR  = {LVDC_OUT_FONT_IDX, 2'h0};
  localparam logic [17:0] LVDC_DISP_CTRL_ADDR = {LVDC_DISP_CTRL_IDX, 2'h0};
  localparam logic [17:0] LVDC_SVD_ADDR       = {LVDC_SVD_IDX, 2'h0};
  localparam logic [17:0] LVDC_CMP_ADDR       = {LVDC_CMP_IDX, 2'h0};
  localparam logic [17:0] LVDC_BUSMODE_ADDR   = {LVDC_BUSMODE_IDX, 2'h0};
  localparam logic [17:0] LVDC_STACKPG_ADDR   = {LVDC_STACKPG_IDX, 2'h0};

  // Field positions
  localparam int LVDC_EIGHTH_DUTY_BIT   = 0;
  localparam int LVDC_PWR_TYPE_BIT      = 1;
  localparam int LVDC_RSV2_BIT          = 2;
  localparam int LVDC_RSV3_BIT          = 3;
  localparam int LVDC_SPARE_BIT         = 0;
  localparam int LVDC_DUTY_SEL_BIT      = 1;
  localparam int LVDC_FONT_BIT          = 2;
  localparam int LVDC_ALT_EN_BIT        = 3;
  localparam int LVDC_LINE_EN_BIT       = 4;
  localparam int LVDC_AREA_BIT          = 6;
  localparam int LVDC_DCTL_LSB          = 4;
  localparam int LVDC_CONTRAST_LSB      = 0;
  localparam int LVDC_AUTO_SAMP_BIT     = 5;
  localparam int LVDC_CONT_SAMP_BIT     = 4;
  localparam int LVDC_LEVEL_LSB         = 0;
  localparam int LVDC_CMP0_EN_BIT       = 2;
  localparam int LVDC_CMP1_EN_BIT       = 3;
  localparam int LVDC_CMP0_DT_BIT       = 0;
  localparam int LVDC_CMP1_DT_BIT       = 1;

  // Reset values
  localparam logic [3:0] LVDC_PWR_DUTY_RST  = 4'h0;
  localparam logic [4:0] LVDC_OUT_FONT_RST  = 5'h00;
  localparam logic [6:0] LVDC_DISP_CTRL_RST = 7'h00;
  localparam logic [3:0] LVDC_LEVEL_RST     = 4'h0;

  typedef enum logic [1:0] {
    LVDC_DISP_OFF    = 2'b00,
    LVDC_DISP_NORMAL = 2'b01,
    LVDC_DISP_BLANK  = 2'b10,
    LVDC_DISP_ALL_ON = 2'b11
  } lvdc_disp_mode_t;

  typedef enum logic [1:0] {
    LVDC_DUTY_32 = 2'b00,
    LVDC_DUTY_16 = 2'b01,
    LVDC_DUTY_8  = 2'b10
  } lvdc_duty_t;

  // Voltage detector handshake: request a sample, get a level back
  typedef struct packed {
    logic       start;
    logic       continuous;
  } lvdc_svd_req_t;

  typedef struct packed {
    logic       done;
    logic [3:0] level;
  } lvdc_svd_rsp_t;

  typedef struct packed {
    lvdc_duty_t      duty;
    logic            power_type_a;
    logic            font_5x5;
    logic            display_area;
    lvdc_disp_mode_t disp_mode;
    logic [3:0]      contrast;
    logic            line_pulse_en;
    logic            alternation_en;
  } lvdc_lcd_cfg_t;

  typedef struct packed {
    logic [3:0] pwr_duty;
    logic [4:0] out_font;
    logic [6:0] disp_ctrl;
    logic       auto_samp;
    logic       cont_samp;
    logic       busy;
    logic       first_done;
    logic       samp_pending;
    logic [3:0] level;
    logic [1:0] cmp_en;
    logic       busmode_written;
    logic       stackpg_written;
    logic [31:0] prdata;
  } lvdc_state_t;

endpackage

// *** design/lvdc_regs.sv ***
// Design decision made here: the APB register port.
`timescale 1ns/1ps

module lvdc_regs
  import lvdc_pkg::*;
#(
  parameter int AUTO_PERIOD = 16
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [17:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic                         pready,
  output logic                         pslverr,
  output logic [31:0]                  prdata,
  input  wire logic                    sleep_instruction,
  output lvdc_pkg::lvdc_lcd_cfg_t      lcd_cfg,
  output lvdc_pkg::lvdc_svd_req_t      svd_req,
  input  wire lvdc_pkg::lvdc_svd_rsp_t svd_rsp,
  input  wire logic [1:0]              cmp_result,
  output logic [1:0]                   cmp_enable,
  output logic                         irq_allowed
);
  import lvdc_pkg::*;

  function automatic logic is_mapped(input logic [17:0] a);
    is_mapped = (a == LVDC_PWR_DUTY_ADDR) || (a == LVDC_OUT_FONT_ADDR) ||
                (a == LVDC_DISP_CTRL_ADDR) || (a == LVDC_SVD_ADDR) ||
                (a == LVDC_CMP_ADDR) || (a == LVDC_BUSMODE_ADDR) ||
                (a == LVDC_STACKPG_ADDR);
  endfunction

  lvdc_state_t s_r;
  lvdc_state_t s_nxt;
  logic [7:0]  auto_cnt_r;
  logic [7:0]  auto_cnt_nxt;
  logic        wr_acc;
  logic        rd_setup;
  logic        svd_start;
  logic [7:0]  wb;
  logic [7:0]  rd8;

  assign wr_acc = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign wb     = pwdata[7:0];

  ////////////////////////////////////////////////////////////////////////
  // Read mux; bits above each register read as zero
  always_comb begin
    rd8 = 8'h00;
    if (paddr == LVDC_PWR_DUTY_ADDR) begin
      rd8[3:0] = s_r.pwr_duty;
    end else if (paddr == LVDC_OUT_FONT_ADDR) begin
      rd8[4:0] = s_r.out_font;
    end else if (paddr == LVDC_DISP_CTRL_ADDR) begin
      rd8[6:0] = s_r.disp_ctrl;
    end else if (paddr == LVDC_SVD_ADDR) begin
      rd8[LVDC_AUTO_SAMP_BIT] = s_r.auto_samp;
      rd8[LVDC_CONT_SAMP_BIT] = s_r.busy || s_r.cont_samp;
      rd8[3:0]                = s_r.level;
    end else if (paddr == LVDC_CMP_ADDR) begin
      rd8[LVDC_CMP1_EN_BIT] = s_r.cmp_en[1];
      rd8[LVDC_CMP0_EN_BIT] = s_r.cmp_en[0];
      rd8[LVDC_CMP1_DT_BIT] = cmp_result[1] & s_r.cmp_en[1];
      rd8[LVDC_CMP0_DT_BIT] = cmp_result[0] & s_r.cmp_en[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt        = s_r;
    auto_cnt_nxt = auto_cnt_r;
    s_nxt.prdata = 32'h0000_0000;
    // Captured in the setup cycle so the data already stands at the access edge
    if (rd_setup) begin
      s_nxt.prdata = {24'h00_0000, rd8};
    end
    if (wr_acc) begin
      if (paddr == LVDC_PWR_DUTY_ADDR) begin
        s_nxt.pwr_duty = wb[3:0];
      end else if (paddr == LVDC_OUT_FONT_ADDR) begin
        s_nxt.out_font = wb[4:0];
      end else if (paddr == LVDC_DISP_CTRL_ADDR) begin
        s_nxt.disp_ctrl = wb[6:0];
      end else if (paddr == LVDC_SVD_ADDR) begin
        s_nxt.auto_samp = wb[LVDC_AUTO_SAMP_BIT];
        s_nxt.cont_samp = wb[LVDC_CONT_SAMP_BIT];
      end else if (paddr == LVDC_CMP_ADDR) begin
        s_nxt.cmp_en = {wb[LVDC_CMP1_EN_BIT], wb[LVDC_CMP0_EN_BIT]};
      end else if (paddr == LVDC_BUSMODE_ADDR) begin
        s_nxt.busmode_written = 1'b1;
      end else if (paddr == LVDC_STACKPG_ADDR) begin
        s_nxt.stackpg_written = 1'b1;
      end
    end
    if (svd_req.start) begin
      s_nxt.samp_pending = 1'b0;
      s_nxt.busy         = 1'b1;
    end
    // Auto sampling paces a request every AUTO_PERIOD cycles; a request raised
    // in the cycle a sample starts survives the clear above
    if (s_r.auto_samp) begin
      if (auto_cnt_r == 8'(AUTO_PERIOD - 1)) begin
        auto_cnt_nxt       = 8'h00;
        s_nxt.samp_pending = 1'b1;
      end else begin
        auto_cnt_nxt = auto_cnt_r + 8'h01;
      end
    end else begin
      auto_cnt_nxt = 8'h00;
    end
    // Completion wins over a new request in the same cycle
    if (svd_rsp.done) begin
      s_nxt.level      = svd_rsp.level;
      s_nxt.first_done = 1'b1;
      s_nxt.busy       = 1'b0;
    end
    if (sleep_instruction) begin
      s_nxt.disp_ctrl[5:4] = LVDC_DISP_OFF;
      s_nxt.auto_samp      = 1'b0;
      s_nxt.cont_samp      = 1'b0;
      s_nxt.samp_pending   = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r                 <= '0;
      s_r.pwr_duty        <= LVDC_PWR_DUTY_RST;
      s_r.out_font        <= LVDC_OUT_FONT_RST;
      s_r.disp_ctrl       <= LVDC_DISP_CTRL_RST;
      s_r.level           <= LVDC_LEVEL_RST;
      s_r.busy            <= 1'b1;
      auto_cnt_r          <= 8'h00;
    end else begin
      s_r        <= s_nxt;
      auto_cnt_r <= auto_cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !is_mapped(paddr);
  assign prdata  = s_r.prdata;

  // No request before the unrequested first sampling ends; one sample in flight at a time
  assign svd_start = s_r.first_done && !s_r.busy && (s_r.samp_pending || s_r.cont_samp);
  assign svd_req   = {svd_start, s_r.cont_samp};

  always_comb begin
    lcd_cfg = '0;
    if (s_r.pwr_duty[LVDC_EIGHTH_DUTY_BIT]) begin
      lcd_cfg.duty = LVDC_DUTY_8;
    end else if (s_r.out_font[LVDC_DUTY_SEL_BIT]) begin
      lcd_cfg.duty = LVDC_DUTY_16;
    end else begin
      lcd_cfg.duty = LVDC_DUTY_32;
    end
    lcd_cfg.power_type_a   = s_r.pwr_duty[LVDC_PWR_TYPE_BIT];
    lcd_cfg.font_5x5       = s_r.out_font[LVDC_FONT_BIT];
    lcd_cfg.line_pulse_en  = s_r.out_font[LVDC_LINE_EN_BIT];
    lcd_cfg.alternation_en = s_r.out_font[LVDC_ALT_EN_BIT];
    lcd_cfg.display_area   = s_r.disp_ctrl[LVDC_AREA_BIT];
    lcd_cfg.disp_mode      = lvdc_disp_mode_t'(s_r.disp_ctrl[5:4]);
    lcd_cfg.contrast       = s_r.disp_ctrl[3:0];
  end

  assign cmp_enable  = s_r.cmp_en;
  assign irq_allowed = s_r.busmode_written && s_r.stackpg_written;

endmodule

// *** testbench/lvdc_regs_chk.sv ***
`timescale 1ns/1ps
module lvdc_chk
  import lvdc_pkg::*;
#(
  parameter int AUTO_PERIOD = 16
) (
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [17:0]             paddr,
  input wire logic [31:0]             pwdata,
  input wire logic                    pslverr,
  input wire logic                    sleep_instruction,
  input wire lvdc_pkg::lvdc_lcd_cfg_t lcd_cfg,
  input wire lvdc_pkg::lvdc_svd_req_t svd_req,
  input wire logic [1:0]              cmp_enable,
  input wire logic                    irq_allowed
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel & penable;
  wire wr  = acc & pwrite;
  wire map = paddr inside {LVDC_PWR_DUTY_ADDR, LVDC_OUT_FONT_ADDR, LVDC_DISP_CTRL_ADDR, LVDC_SVD_ADDR, LVDC_CMP_ADDR};
  wire ctl = paddr inside {LVDC_BUSMODE_ADDR, LVDC_STACKPG_ADDR};
  property p_err; acc && !map && !ctl |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("no error on unmapped access");
  property p_noerr; acc && map |-> !pslverr; endproperty
  a_noerr: assert property (p_noerr) else $error("error on mapped access");
  property p_slp_disp; sleep_instruction |=> lcd_cfg.disp_mode == LVDC_DISP_OFF; endproperty
  a_slp_disp: assert property (p_slp_disp) else $error("drive not off after sleep");
  property p_slp_svd; sleep_instruction |=> !svd_req.continuous; endproperty
  a_slp_svd: assert property (p_slp_svd) else $error("sampling on after sleep");
  property p_irq; $rose(irq_allowed) |-> $past(wr && ctl); endproperty
  a_irq: assert property (p_irq) else $error("interrupts opened without a control write");
  property p_disp;
    wr && paddr == LVDC_DISP_CTRL_ADDR && !sleep_instruction |=>
      lcd_cfg.contrast == $past(pwdata[3:0]) && lcd_cfg.disp_mode == $past(pwdata[5:4]);
  endproperty
  a_disp: assert property (p_disp) else $error("display control not taken");
  property p_eighth_duty_switch; wr && paddr == LVDC_PWR_DUTY_ADDR && pwdata[0] |=> lcd_cfg.duty == LVDC_DUTY_8; endproperty
  a_eighth_duty_switch: assert property (p_eighth_duty_switch) else $error("eighth duty not selected");
  property p_out;
    wr && paddr == LVDC_OUT_FONT_ADDR |=>
      {lcd_cfg.line_pulse_en, lcd_cfg.alternation_en, lcd_cfg.font_5x5} == $past(pwdata[4:2]);
  endproperty
  a_out: assert property (p_out) else $error("output or font bits not taken");
  property p_cmp; wr && paddr == LVDC_CMP_ADDR |=> cmp_enable == $past(pwdata[3:2]); endproperty
  a_cmp: assert property (p_cmp) else $error("comparator enables not taken");
  c_sleep: cover property (sleep_instruction);
  c_irq: cover property ($rose(irq_allowed));
  c_err: cover property (acc && !map && !ctl);
endmodule
bind lvdc_regs lvdc_chk #(.AUTO_PERIOD(AUTO_PERIOD)) lvdc_chk_inst (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pslverr, .sleep_instruction, .lcd_cfg, .svd_req, .cmp_enable, .irq_allowed);

// *** testbench/lvdc_regs_test.sv ***
`timescale 1ns/1ps
module lvdc_regs_test;
  import lvdc_pkg::*;
  logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, sleep_instruction, irq_allowed;
  logic [17:0]   paddr;
  logic [31:0]   pwdata, prdata;
  logic [1:0]    cmp_result, cmp_enable;
  lvdc_lcd_cfg_t lcd_cfg, e;
  lvdc_svd_req_t svd_req;
  lvdc_svd_rsp_t svd_rsp;
  logic [7:0]    rd;
  logic          er;
  int            bad_count, checks_done;
  logic [17:0]   ad [4] = '{LVDC_PWR_DUTY_ADDR, LVDC_OUT_FONT_ADDR, LVDC_DISP_CTRL_ADDR, LVDC_CMP_ADDR};
  logic [7:0]    msk [4] = '{8'h0F, 8'h1F, 8'h7F, 8'h0E};
  lvdc_regs lvdc_regs_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
    .prdata, .sleep_instruction, .lcd_cfg, .svd_req, .svd_rsp, .cmp_result, .cmp_enable, .irq_allowed);
  lvdc_svd_model lvdc_svd_model_inst (.pclk, .presetn, .svd_req, .svd_rsp);
  always #20 pclk = ~pclk;
  ////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [17:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    // Error flag and read data are taken at the access edge itself
    er = pslverr;
    rd = prdata[7:0];
    psel <= 1'b0;
    penable <= 1'b0;
    // Register outputs settle before callers compare them
    @(negedge pclk);
  endtask
  task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
    checks_done++;
    if (g !== x) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    #200000 bad_count++;
    report_and_stop();
  end
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    sleep_instruction = 0; cmp_result = 2'b10;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, LVDC_SVD_ADDR, 0); chk("busy", 8'h10, rd & 8'h10);
    for (int i = 0; i < 4; i++) begin
      apb(0, ad[i], 0); chk("reset", 0, rd);
      apb(1, ad[i], 8'hFF); apb(0, ad[i], 0); chk("readback", msk[i], rd);
    end
    @(posedge pclk) cmp_result <= 2'b01;
    apb(0, LVDC_CMP_ADDR, 0); chk("cmp data", 8'h0D, rd);
    e = '{LVDC_DUTY_8, 1'b1, 1'b1, 1'b1, LVDC_DISP_ALL_ON, 4'hF, 1'b1, 1'b1};
    chk("cfg", e, lcd_cfg);
    apb(1, LVDC_PWR_DUTY_ADDR, 0); chk("duty16", LVDC_DUTY_16, lcd_cfg.duty);
    apb(1, LVDC_OUT_FONT_ADDR, 0); chk("duty32", LVDC_DUTY_32, lcd_cfg.duty);
    for (int m = 0; m < 4; m++) begin
      apb(1, LVDC_DISP_CTRL_ADDR, {2'b0, m[1:0], 4'h5}); chk("mode", m[1:0], lcd_cfg.disp_mode);
    end
    $display("test cfg done");
    repeat (30) @(posedge pclk);
    apb(0, LVDC_SVD_ADDR, 0); chk("level", 8'h0A, rd);
    apb(1, LVDC_SVD_ADDR, 8'h0F); apb(0, LVDC_SVD_ADDR, 0); chk("level ro", 8'h0A, rd);
    apb(1, LVDC_SVD_ADDR, 8'h30); chk("cont", 1, svd_req.continuous);
    apb(0, LVDC_SVD_ADDR, 0); chk("auto", 8'h20, rd & 8'h20);
    chk("cont busy", 8'h10, rd & 8'h10);
    apb(1, LVDC_DISP_CTRL_ADDR, 8'h15);
    @(posedge pclk) sleep_instruction <= 1'b1;
    @(posedge pclk) sleep_instruction <= 1'b0;
    repeat (10) @(posedge pclk);
    apb(0, LVDC_SVD_ADDR, 0); chk("svd sleep", 8'h0A, rd);
    apb(0, LVDC_DISP_CTRL_ADDR, 0); chk("disp sleep", 8'h05, rd);
    $display("test svd done");
    apb(1, 18'h3FFFC, 8'hFF); chk("err w", 1, er);
    apb(0, 18'h3FFFC, 0); chk("err r", 1, er); chk("err data", 0, rd);
    chk("irq0", 0, irq_allowed);
    apb(1, LVDC_BUSMODE_ADDR, 0); chk("irq1", 0, irq_allowed);
    apb(1, LVDC_STACKPG_ADDR, 0); chk("irq2", 1, irq_allowed);
    $display("test bus done");
    report_and_stop();
  end
endmodule

// *** testbench/lvdc_svd_model.sv ***
`timescale 1ns/1ps
module lvdc_svd_model
  import lvdc_pkg::*;
#(
  parameter logic [3:0] LEVEL = 4'hA
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire lvdc_pkg::lvdc_svd_req_t svd_req,
  output lvdc_pkg::lvdc_svd_rsp_t      svd_rsp
);
  int cnt;
  // First sampling runs unrequested after reset, later ones take three cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 20;
      svd_rsp <= {1'b0, ~LEVEL};
    end else if (cnt == 1) begin
      cnt <= 0;
      svd_rsp <= {1'b1, LEVEL};
    end else begin
      // Level toggles outside the done pulse so a stale value never looks valid
      svd_rsp <= {1'b0, ~svd_rsp.level};
      if (cnt > 1) cnt <= cnt - 1;
      else if (svd_req.start) cnt <= 3;
    end
  end
endmodule
